/* verilog/cgm_defines.svh */
// constants for the control gain readback and monitor channel one registers
`ifndef CGM_DEFINES_SVH
`define CGM_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define CGM_IDX_CURRENT_GAIN 8'hF0
`define CGM_IDX_SPEED_GAIN 8'hF2
`define CGM_IDX_MON1_CFG 8'hF4

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CGM_GAIN_I_LSB 16
`define CGM_GAIN_P_LSB 0
`define CGM_GAIN_W 10
`define CGM_MON1_CFG_W 21
`define CGM_POW2_MSB 20
`define CGM_POW2_LSB 17
`define CGM_FRAC_MSB 16
`define CGM_FRAC_LSB 13
`define CGM_POL_BIT 12
`define CGM_VADDR_MSB 11
`define CGM_VADDR_LSB 0

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CGM_GAIN_RESET 32'h00000000
`define CGM_MON1_CFG_RESET 21'h110000

////////////////////////////////////////////////////////////////////////////////
// monitor scaling: variable is signed 16 bit, one pu is 2**14
`define CGM_VAR_W 16
`define CGM_PU_SHIFT 14
`define CGM_FRAC_SHIFT 3
`define CGM_DAC_W 12
`define CGM_DAC_MAX 12'hFFF

`endif

/* verilog/cgm_pkg.sv */
// types shared by the gain readback and monitor channel logic
package cgm_pkg;

	typedef enum logic {
		CGM_BIPOLAR,
		CGM_UNIPOLAR
	} cgm_polarity_t;

	typedef enum logic [1:0] {
		CGM_SEL_NONE,
		CGM_SEL_CURRENT,
		CGM_SEL_SPEED,
		CGM_SEL_MON1
	} cgm_reg_sel_t;

endpackage : cgm_pkg

/* verilog/cgm_mon_scale.sv */
// monitor channel scaling and voltage mapping to a 12-bit output code
`include "cgm_defines.svh"

module cgm_mon_scale (
	input wire logic clk,
	input wire logic nrst,
	input wire logic signed [15:0] variable_value,
	input wire logic [3:0] fractional_scale,
	input wire logic [3:0] power_of_two_scale,
	input wire cgm_pkg::cgm_polarity_t polarity,
	output logic [11:0] code
);

	logic [11:0] next_code;

	always_comb begin
		logic signed [35:0] scaled;
		logic signed [35:0] shifted;
		scaled = 36'sh0;
		shifted = 36'sh0;
		if (fractional_scale == 4'h0) begin
			scaled = 36'(variable_value) <<< power_of_two_scale;
		end else begin
			scaled = (36'(variable_value) * $signed({32'h0, fractional_scale}))
				>>> `CGM_FRAC_SHIFT;
		end
		// full span of the code covers 1 pu unipolar, 2 pu bipolar
		if (polarity == cgm_pkg::CGM_UNIPOLAR) begin
			shifted = scaled >>> (`CGM_PU_SHIFT - `CGM_DAC_W);
		end else begin
			shifted = (scaled + (36'sh1 <<< `CGM_PU_SHIFT))
				>>> (`CGM_PU_SHIFT + 1 - `CGM_DAC_W);
		end
		// saturate rather than wrap, so overrange reads as a rail
		if (shifted < 36'sh0) begin
			next_code = 12'h000;
		end else if (shifted > 36'(`CGM_DAC_MAX)) begin
			next_code = `CGM_DAC_MAX;
		end else begin
			next_code = shifted[11:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			code <= 12'h000;
		end else begin
			code <= next_code;
		end
	end

endmodule : cgm_mon_scale

/* verilog/cgm_regs.sv */
// AHB-Lite register bank: gain readbacks and monitor channel one config
`include "cgm_defines.svh"

module cgm_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [9:0] active_current_integral_gain,
	input wire logic [9:0] active_current_proportional_gain,
	input wire logic [9:0] active_speed_integral_gain,
	input wire logic [9:0] active_speed_proportional_gain,
	output logic [11:0] mon1_variable_address,
	input wire logic signed [15:0] mon1_variable_value,
	output logic [11:0] monitor_output_one
);

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [31:0] current_gain_readback;
	logic [31:0] next_current_gain_readback;
	logic [31:0] speed_gain_readback;
	logic [31:0] next_speed_gain_readback;
	logic [20:0] monitor_channel_one_config;
	logic [20:0] next_monitor_channel_one_config;
	logic wr_pending;
	logic next_wr_pending;
	cgm_pkg::cgm_reg_sel_t wr_sel;
	cgm_pkg::cgm_reg_sel_t next_wr_sel;
	logic [31:0] next_hrdata;

	logic addr_phase;
	cgm_pkg::cgm_reg_sel_t addr_sel;
	logic [3:0] mon1_fractional_scale;
	logic [3:0] mon1_power_of_two_scale;
	cgm_pkg::cgm_polarity_t mon1_polarity_select;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic cgm_pkg::cgm_reg_sel_t cgm_decode(
		input logic [31:0] addr
	);
		cgm_pkg::cgm_reg_sel_t sel;
		sel = cgm_pkg::CGM_SEL_NONE;
		// only aligned words inside the low 1 KiB window decode
		if (addr[31:10] == 22'h000000 && addr[1:0] == 2'h0) begin
			if (addr[9:2] == `CGM_IDX_CURRENT_GAIN) begin
				sel = cgm_pkg::CGM_SEL_CURRENT;
			end else if (addr[9:2] == `CGM_IDX_SPEED_GAIN) begin
				sel = cgm_pkg::CGM_SEL_SPEED;
			end else if (addr[9:2] == `CGM_IDX_MON1_CFG) begin
				sel = cgm_pkg::CGM_SEL_MON1;
			end
		end
		return sel;
	endfunction : cgm_decode

	// every access finishes in its first data-phase cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;
	assign addr_sel = cgm_decode(haddr);

	////////////////////////////////////////////////////////////////////////////
	// write path: address phase captured, data taken one cycle later

	always_comb begin
		next_wr_pending = addr_phase && hwrite;
		next_wr_sel = addr_sel;
		if (!(addr_phase && hwrite)) begin
			next_wr_sel = cgm_pkg::CGM_SEL_NONE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pending <= 1'b0;
			wr_sel <= cgm_pkg::CGM_SEL_NONE;
		end else begin
			wr_pending <= next_wr_pending;
			wr_sel <= next_wr_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// gain readbacks: refreshed every cycle from the live controller gains

	always_comb begin
		next_current_gain_readback = `CGM_GAIN_RESET;
		next_speed_gain_readback = `CGM_GAIN_RESET;
		next_current_gain_readback[`CGM_GAIN_I_LSB +: `CGM_GAIN_W] =
			active_current_integral_gain;
		next_current_gain_readback[`CGM_GAIN_P_LSB +: `CGM_GAIN_W] =
			active_current_proportional_gain;
		next_speed_gain_readback[`CGM_GAIN_I_LSB +: `CGM_GAIN_W] =
			active_speed_integral_gain;
		next_speed_gain_readback[`CGM_GAIN_P_LSB +: `CGM_GAIN_W] =
			active_speed_proportional_gain;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			current_gain_readback <= `CGM_GAIN_RESET;
			speed_gain_readback <= `CGM_GAIN_RESET;
		end else begin
			current_gain_readback <= next_current_gain_readback;
			speed_gain_readback <= next_speed_gain_readback;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// monitor channel one configuration

	always_comb begin
		next_monitor_channel_one_config = monitor_channel_one_config;
		// writes to the readbacks fall through here untouched
		if (wr_pending && wr_sel == cgm_pkg::CGM_SEL_MON1) begin
			// upper bits are not stored at all
			next_monitor_channel_one_config =
				hwdata[`CGM_MON1_CFG_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			monitor_channel_one_config <= `CGM_MON1_CFG_RESET;
		end else begin
			monitor_channel_one_config <= next_monitor_channel_one_config;
		end
	end

	assign mon1_variable_address = monitor_channel_one_config[
		`CGM_VADDR_MSB:`CGM_VADDR_LSB];
	assign mon1_fractional_scale = monitor_channel_one_config[
		`CGM_FRAC_MSB:`CGM_FRAC_LSB];
	assign mon1_power_of_two_scale = monitor_channel_one_config[
		`CGM_POW2_MSB:`CGM_POW2_LSB];
	assign mon1_polarity_select = cgm_pkg::cgm_polarity_t'(
		monitor_channel_one_config[`CGM_POL_BIT]);

	////////////////////////////////////////////////////////////////////////////
	// read path
	// read data is taken from the next values so that a write in the data
	// phase just before a read is seen, at the cost of a longer comb path

	always_comb begin
		next_hrdata = 32'h00000000;
		if (addr_phase && !hwrite) begin
			unique case (addr_sel)
				cgm_pkg::CGM_SEL_CURRENT: begin
					next_hrdata = next_current_gain_readback;
				end
				cgm_pkg::CGM_SEL_SPEED: begin
					next_hrdata = next_speed_gain_readback;
				end
				cgm_pkg::CGM_SEL_MON1: begin
					next_hrdata = {11'h000,
						next_monitor_channel_one_config};
				end
				cgm_pkg::CGM_SEL_NONE: begin
					next_hrdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// monitor output channel one

	cgm_mon_scale u_mon1_scale (
		.clk(clk),
		.nrst(nrst),
		.variable_value(mon1_variable_value),
		.fractional_scale(mon1_fractional_scale),
		.power_of_two_scale(mon1_power_of_two_scale),
		.polarity(mon1_polarity_select),
		.code(monitor_output_one)
	);

endmodule : cgm_regs

/* tb/cgm_regs_properties.sv */
// checker for readback, config and monitor output timing of cgm_regs
module cgm_regs_properties (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic [9:0] active_current_integral_gain,
	input wire logic [9:0] active_current_proportional_gain,
	input wire logic [9:0] active_speed_integral_gain,
	input wire logic [9:0] active_speed_proportional_gain,
	input wire logic [11:0] mon1_variable_address,
	input wire logic signed [15:0] mon1_variable_value,
	input wire logic [11:0] monitor_output_one
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic wr_d;
	logic [20:0] cfg_m;
	logic [35:0] p2;
	logic [11:0] exp_p2;
	////////////////////////////////////////////////////////////////////////
	// mirror of the config word, so output checks know the live scaling
	always_comb begin
		p2 = 36'h000000001 << cfg_m[20:17];
		exp_p2 = (p2[35:2] > 34'h000000FFF) ? 12'hFFF : p2[13:2];
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_d <= 1'b0;
			cfg_m <= 21'h110000;
		end else begin
			wr_d <= hsel && htrans[1] && hready && hwrite
				&& haddr == 32'h000003D0;
			if (wr_d)
				cfg_m <= hwdata[20:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_rd(a);
		hsel && htrans[1] && hready && !hwrite && haddr == a;
	endsequence
	sequence s_wr_cfg;
		hsel && htrans[1] && hready && hwrite && haddr == 32'h000003D0
			##1 1'b1;
	endsequence
	property p_cur_gain;
		s_rd(32'h000003C0) |=> hrdata == {6'h00,
			$past(active_current_integral_gain), 6'h00,
			$past(active_current_proportional_gain)};
	endproperty
	property p_spd_gain;
		s_rd(32'h000003C8) |=> hrdata == {6'h00,
			$past(active_speed_integral_gain), 6'h00,
			$past(active_speed_proportional_gain)};
	endproperty
	property p_cfg_rd;
		s_rd(32'h000003D0) |=> hrdata == {11'h000, cfg_m};
	endproperty
	property p_addr;
		s_wr_cfg |=> mon1_variable_address == $past(hwdata[11:0]);
	endproperty
	property p_uni_zero;
		cfg_m[12] && cfg_m[16:13] == 4'h8 && mon1_variable_value == 16'sh0000
			|=> monitor_output_one == 12'h000;
	endproperty
	property p_bip_mid;
		!cfg_m[12] && cfg_m[16:13] == 4'h8 && mon1_variable_value == 16'sh0000
			|=> monitor_output_one == 12'h800;
	endproperty
	property p_frac;
		cfg_m[12] && cfg_m[16:13] == 4'h4 && mon1_variable_value == 16'sh4000
			|=> monitor_output_one == 12'h800;
	endproperty
	property p_pow2;
		cfg_m[12] && cfg_m[16:13] == 4'h0 && mon1_variable_value == 16'sh0001
			|=> monitor_output_one == $past(exp_p2);
	endproperty
	a_cur_gain: assert property (p_cur_gain)
		else $error("current gain readback wrong");
	a_spd_gain: assert property (p_spd_gain)
		else $error("speed gain readback wrong");
	a_cfg_rd: assert property (p_cfg_rd)
		else $error("config readback wrong");
	a_addr: assert property (p_addr)
		else $error("variable address not updated");
	a_uni_zero: assert property (p_uni_zero)
		else $error("unipolar zero code wrong");
	a_bip_mid: assert property (p_bip_mid)
		else $error("bipolar offset code wrong");
	a_frac: assert property (p_frac)
		else $error("fractional scaling wrong");
	a_pow2: assert property (p_pow2)
		else $error("power of two scaling wrong");
endmodule : cgm_regs_properties

bind cgm_regs cgm_regs_properties chk_u (.clk, .nrst, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata,
	.active_current_integral_gain, .active_current_proportional_gain,
	.active_speed_integral_gain, .active_speed_proportional_gain,
	.mon1_variable_address, .mon1_variable_value, .monitor_output_one);

/* tb/tb.sv */
// testbench: bus access, gain readback and monitor channel one output
`define CHK(n, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("MISMATCH %s expected %h seen %h", n, e, g); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] cki, ckp, ski, skp;
	logic [11:0] vaddr, mout;
	logic signed [15:0] vval;
	int fails, tests_run;
	logic [31:0] cfg_t [8] = '{32'h00111000, 32'h00111000, 32'h00111000,
		32'h00110000, 32'h00110000, 32'h00109000, 32'h00181000, 32'h00000000};
	logic [15:0] val_t [8] = '{16'h2000, 16'h0000, 16'hE000, 16'hC000,
		16'h3FFF, 16'h4000, 16'h0001, 16'h0800};
	logic [11:0] exp_t [8] = '{12'h800, 12'h000, 12'h000, 12'h000,
		12'hFFF, 12'h800, 12'h400, 12'h900};
	// one slave on the bus, so its ready is the bus ready
	assign hready = hreadyout;
	cgm_regs dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.active_current_integral_gain(cki),
		.active_current_proportional_gain(ckp),
		.active_speed_integral_gain(ski),
		.active_speed_proportional_gain(skp),
		.mon1_variable_address(vaddr), .mon1_variable_value(vval),
		.monitor_output_one(mout));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			fails++;
			tally_and_finish;
		end
	endtask : wait_rdy
	// entered just after a rising edge; returns just after the data edge
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask : bus
	task automatic chk_rd(input string n, input logic [31:0] a, e);
		bus(1'b0, a, 32'h00000000);
		`CHK(n, e, q)
		`CHK("resp", 1'b0, hresp)
		@(posedge clk);
		`CHK("rd idle", 32'h00000000, hrdata)
	endtask : chk_rd
	////////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		tests_run = 0;
		nrst <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h00000000;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h00000000;
		cki <= 10'h3FF;
		ckp <= 10'h155;
		ski <= 10'h2AA;
		skp <= 10'h001;
		vval <= 16'sh0000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		chk_rd("cfg reset", 32'h000003D0, 32'h00110000);
		chk_rd("cur gain", 32'h000003C0, 32'h03FF0155);
		chk_rd("spd gain", 32'h000003C8, 32'h02AA0001);
		bus(1'b1, 32'h000003C0, 32'hFFFFFFFF);
		cki <= 10'h001;
		chk_rd("cur gain live", 32'h000003C0, 32'h00010155);
		$display("test gains done");
		bus(1'b1, 32'h000003D0, 32'hFFFFFFFF);
		chk_rd("cfg reserved", 32'h000003D0, 32'h001FFFFF);
		`CHK("var addr", 12'hFFF, vaddr)
		bus(1'b1, 32'h000003D4, 32'hFFFFFFFF);
		chk_rd("unmapped", 32'h000003D4, 32'h00000000);
		$display("test config done");
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 32'h000003D0, cfg_t[i]);
			vval <= val_t[i];
			repeat (3) @(posedge clk);
			`CHK("monitor out", exp_t[i], mout)
		end
		$display("test monitor done");
		tally_and_finish;
	end
endmodule : tb
